// ===== rtl/hbg_map.svh
// register offsets, field positions, reset values and timing counts of the
// h-bridge gate control block; definitions only
`ifndef HBG_MAP_SVH
`define HBG_MAP_SVH

`define HBG_ADDR_W          8
`define HBG_CTRL_OFS        8'h00
`define HBG_STAT_OFS        8'h04

// control register fields
`define HBG_CTRL_UA_BIT     0
`define HBG_CTRL_LA_BIT     1
`define HBG_CTRL_UB_BIT     2
`define HBG_CTRL_LB_BIT     3
`define HBG_CTRL_SEL_LO     4
`define HBG_CTRL_SEL_HI     5
`define HBG_CTRL_OLI_BIT    6
`define HBG_CTRL_W          7
`define HBG_CTRL_RST        7'h00

// status register fields
`define HBG_STAT_GATE_LO    0
`define HBG_STAT_FLT_BIT    4
`define HBG_STAT_SLP_BIT    5
`define HBG_STAT_EN_BIT     6
`define HBG_STAT_W          7

// pin synchroniser order and idle levels
`define HBG_PIN_W           7
`define HBG_PIN_RST         7'h26

// timing
`define HBG_CLK_HZ          20000000
`define HBG_PULSE_PERIOD_MS 100
`define HBG_PULSE_CYC       (`HBG_PULSE_PERIOD_MS * (`HBG_CLK_HZ / 1000))
`define HBG_DUTY_FAULT_PCT  80
`define HBG_DUTY_OK_PCT     20
`define HBG_SLEEP_HOLD_US   1000
`define HBG_SLEEP_CYC       (`HBG_SLEEP_HOLD_US * (`HBG_CLK_HZ / 1000000))

`endif

// ===== rtl/hbg_pkg.sv
// types shared by the h-bridge gate control block
// assumes nothing of its surroundings
package hbg_pkg;
  typedef enum logic [1:0] {
    HBG_FAULT_REPORT_PIN_FLAG   = 2'b00,
    HBG_FAULT_REPORT_PIN_PULSE  = 2'b01,
    HBG_FAULT_REPORT_PIN_TEMP   = 2'b10,
    HBG_FAULT_REPORT_PIN_OFFSET = 2'b11
  } hbg_fault_report_pin_mode_t;

  typedef enum logic [1:0] {
    HBG_RESP_OKAY   = 2'b00,
    HBG_RESP_SLVERR = 2'b10
  } hbg_resp_t;
endpackage

// ===== rtl/hbg_phase.sv
// one bridge phase: lockout and registered gate drive
// assumes requests are already synchronised and active high
`timescale 1ns/10ps
`default_nettype none
module hbg_phase (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic allow,
  input  wire logic hi_req,
  input  wire logic lo_req,
  output var  logic upper_gate,
  output var  logic lower_gate
);
  logic upper_nxt;
  logic lower_nxt;

  assign upper_nxt = allow & hi_req & ~lo_req;  // RQ1
  assign lower_nxt = allow & lo_req & ~hi_req;  // RQ3

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_gate <= 1'b0;
      lower_gate <= 1'b0;
    end else begin
      upper_gate <= upper_nxt;
      lower_gate <= lower_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_lockout;
    hi_req && lo_req |=> !upper_gate && !lower_gate;
  endproperty
  a_lockout: assert property (p_lockout) else $error("both requests did not force off"); // RQ5

  property p_single_high;
    allow && hi_req && !lo_req |=> upper_gate && !lower_gate;
  endproperty
  a_single_high: assert property (p_single_high) else $error("upper gate not driven"); // RQ1
endmodule
`default_nettype wire

// ===== rtl/hbg_pulse.sv
// pulsed fault flag generator: fixed period, duty from fault state
// assumes run and fault come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "hbg_map.svh"
module hbg_pulse #(
  parameter int unsigned PERIOD = `HBG_PULSE_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic fault,
  output var  logic pulse
);
  localparam int unsigned CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  localparam logic [CW-1:0] HI_FLT = CW'((64'(PERIOD) * `HBG_DUTY_FAULT_PCT) / 100);
  localparam logic [CW-1:0] HI_OK  = CW'((64'(PERIOD) * `HBG_DUTY_OK_PCT) / 100);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] high_len;

  assign cnt_nxt  = (!run || cnt_r == LAST) ? '0 : cnt_r + CW'(1);  // RQ7
  assign high_len = fault ? HI_FLT : HI_OK;                         // RQ8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      pulse <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pulse <= run & (cnt_nxt < high_len);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wrap;
    run && cnt_r == LAST |=> cnt_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pulse period did not wrap"); // RQ7

  property p_duty_fault;
    run && $past(run) && $past(fault) |-> pulse == (cnt_r < HI_FLT);
  endproperty
  a_duty_fault: assert property (p_duty_fault) else $error("fault duty wrong"); // RQ8

  property p_duty_ok;
    run && $past(run) && !$past(fault) |-> pulse == (cnt_r < HI_OK);
  endproperty
  a_duty_ok: assert property (p_duty_ok) else $error("no-fault duty wrong"); // RQ8
endmodule
`default_nettype wire

// ===== rtl/hbg_top.sv
// h-bridge gate control: pin and register bridge control, lockout,
// fault flag output modes and open-load current select, axi4-lite slave
// assumes a single 20 MHz clock; all pins are asynchronous to it
`timescale 1ns/10ps
`default_nettype none
`include "hbg_map.svh"

// Overview of operation
// (RQ1) pins: lone high or low request drives gate
// (RQ2) pin mapping needs enable, reset-pin high
// (RQ3) register bits: lone bit drives its gate
// (RQ4) register mapping needs idle pins, enable high
// (RQ5) pin OR register; both requests turn off
// (RQ6) combined mapping only with reset-pin, enable high
// (RQ7) select 01: diagnostic pin pulses, 100 ms
// (RQ8) pulse high 80% with fault, else 20%
// (RQ9) select bit picks 100 or 400 microamp
// (RQ10) enable low switches all gates off
// (RQ11) short reset-pin pulse clears; held low sleeps
// (RQ12) host avoids requesting both gates of phase
module hbg_top #(
  parameter int unsigned PULSE_CYC = `HBG_PULSE_CYC,
  parameter int unsigned SLEEP_CYC = `HBG_SLEEP_CYC
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`HBG_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output var  logic                   awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output var  logic                   wready,
  output var  hbg_pkg::hbg_resp_t     bresp,
  output var  logic                   bvalid,
  input  wire logic                   bready,
  input  wire logic [`HBG_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output var  logic                   arready,
  output var  logic [31:0]            rdata,
  output var  hbg_pkg::hbg_resp_t     rresp,
  output var  logic                   rvalid,
  input  wire logic                   rready,
  input  wire logic                   phase_a_upper_req,
  input  wire logic                   phase_a_lower_req_n,
  input  wire logic                   phase_b_upper_req_n,
  input  wire logic                   phase_b_lower_req,
  input  wire logic                   gate_enable,
  input  wire logic                   fault_clear_sleep_n,
  input  wire logic                   fault_present,
  output var  logic                   phase_a_upper_gate,
  output var  logic                   phase_a_lower_gate,
  output var  logic                   phase_b_upper_gate,
  output var  logic                   phase_b_lower_gate,
  output var  logic                   fault_report_pin,
  output var  logic                   openload_current_sel,
  output var  logic                   sleep_active
);
  import hbg_pkg::*;

  localparam int unsigned SW = $clog2(SLEEP_CYC + 1);
  localparam logic [SW-1:0] SLEEP_LAST = SW'(SLEEP_CYC);

  // pin synchroniser, bit order: a_up, a_lo_n, b_up_n, b_lo, en, clr_n, flt
  logic [`HBG_PIN_W-1:0] pin_meta_r;
  logic [`HBG_PIN_W-1:0] pin_sync_r;
  logic [`HBG_PIN_W-1:0] pin_raw;

  assign pin_raw = {fault_present, fault_clear_sleep_n, gate_enable, phase_b_lower_req,
                    phase_b_upper_req_n, phase_a_lower_req_n, phase_a_upper_req};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= `HBG_PIN_RST;
      pin_sync_r <= `HBG_PIN_RST;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  logic a_up_s;
  logic a_lo_n_s;
  logic b_up_n_s;
  logic b_lo_s;
  logic en_s;
  logic clr_n_s;
  logic flt_s;

  assign a_up_s   = pin_sync_r[0];
  assign a_lo_n_s = pin_sync_r[1];
  assign b_up_n_s = pin_sync_r[2];
  assign b_lo_s   = pin_sync_r[3];
  assign en_s     = pin_sync_r[4];
  assign clr_n_s  = pin_sync_r[5];
  assign flt_s    = pin_sync_r[6];

  // control register
  logic [`HBG_CTRL_W-1:0] ctrl_r;
  hbg_fault_report_pin_mode_t         fault_report_pin_mode;

  assign fault_report_pin_mode = hbg_fault_report_pin_mode_t'(ctrl_r[`HBG_CTRL_SEL_HI:`HBG_CTRL_SEL_LO]);

  // reset pin: short low clears faults, long low puts the bridge asleep
  logic [SW-1:0] low_cnt_r;
  logic          clr_n_d_r;
  logic          fault_latched_r;
  logic          fault_clear;
  logic          sleep_set;

  assign sleep_set   = !clr_n_s && low_cnt_r == SLEEP_LAST;
  assign fault_clear = clr_n_s && !clr_n_d_r && !sleep_active;  // RQ11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r       <= '0;
      clr_n_d_r       <= 1'b1;
      fault_latched_r <= 1'b0;
      sleep_active    <= 1'b0;
    end else begin
      clr_n_d_r       <= clr_n_s;
      low_cnt_r       <= clr_n_s ? '0 : (sleep_set ? low_cnt_r : low_cnt_r + SW'(1));
      fault_latched_r <= flt_s | (fault_latched_r & ~fault_clear);
      sleep_active    <= clr_n_s ? 1'b0 : (sleep_active | sleep_set);  // RQ11
    end
  end

  // gate requests: pin request OR register bit per gate
  logic allow;
  logic hi_a;
  logic lo_a;
  logic hi_b;
  logic lo_b;

  assign allow = en_s & clr_n_s;  // RQ2 RQ4 RQ6 RQ10
  assign hi_a  = a_up_s | ctrl_r[`HBG_CTRL_UA_BIT];     // RQ5
  assign lo_a  = ~a_lo_n_s | ctrl_r[`HBG_CTRL_LA_BIT];  // RQ5
  assign hi_b  = ~b_up_n_s | ctrl_r[`HBG_CTRL_UB_BIT];  // RQ5
  assign lo_b  = b_lo_s | ctrl_r[`HBG_CTRL_LB_BIT];     // RQ5

  hbg_phase u_phase_a (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .allow      (allow),
    .hi_req     (hi_a),
    .lo_req     (lo_a),
    .upper_gate (phase_a_upper_gate),
    .lower_gate (phase_a_lower_gate)
  );

  hbg_phase u_phase_b (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .allow      (allow),
    .hi_req     (hi_b),
    .lo_req     (lo_b),
    .upper_gate (phase_b_upper_gate),
    .lower_gate (phase_b_lower_gate)
  );

  // diagnostic output
  logic fault_any;
  logic pulse_run;
  logic pulse_out;
  logic fault_report_pin_nxt;

  assign fault_any = flt_s | fault_latched_r;
  assign pulse_run = fault_report_pin_mode == HBG_FAULT_REPORT_PIN_PULSE;  // RQ7

  hbg_pulse #(
    .PERIOD (PULSE_CYC)
  ) u_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (pulse_run),
    .fault   (fault_any),
    .pulse   (pulse_out)
  );

  // analogue modes are outside this block and read low here
  assign fault_report_pin_nxt = (fault_report_pin_mode == HBG_FAULT_REPORT_PIN_FLAG) ? fault_any :
                    (pulse_run ? pulse_out : 1'b0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_report_pin     <= 1'b0;
      openload_current_sel <= 1'b0;
    end else begin
      fault_report_pin     <= fault_report_pin_nxt;
      openload_current_sel <= ctrl_r[`HBG_CTRL_OLI_BIT];  // RQ9
    end
  end

  // axi4-lite write channel
  logic [`HBG_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic                   wstrb0_q;
  logic                   aw_hold_r;
  logic                   w_hold_r;
  logic                   do_write;
  logic                   wr_ctrl;
  logic                   wr_stat;

  assign do_write = aw_hold_r & w_hold_r & ~bvalid;
  assign wr_ctrl  = {awaddr_q[`HBG_ADDR_W-1:2], 2'b00} == `HBG_CTRL_OFS;
  assign wr_stat  = {awaddr_q[`HBG_ADDR_W-1:2], 2'b00} == `HBG_STAT_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= HBG_RESP_OKAY;
      ctrl_r    <= `HBG_CTRL_RST;
    end else begin
      if (awvalid && awready) begin
        awaddr_q  <= awaddr;
        aw_hold_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q  <= wdata;
        wstrb0_q <= wstrb[0];
        w_hold_r <= 1'b1;
        wready   <= 1'b0;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (wr_ctrl || wr_stat) ? HBG_RESP_OKAY : HBG_RESP_SLVERR;
        if (wr_ctrl && wstrb0_q) begin
          ctrl_r <= wdata_q[`HBG_CTRL_W-1:0];  // RQ3
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  logic [`HBG_STAT_W-1:0] stat;
  logic [31:0]            rd_mux;
  logic                   rd_ctrl;
  logic                   rd_stat;

  assign stat    = {en_s, sleep_active, fault_latched_r, phase_b_lower_gate,
                    phase_b_upper_gate, phase_a_lower_gate, phase_a_upper_gate};
  assign rd_ctrl = {araddr[`HBG_ADDR_W-1:2], 2'b00} == `HBG_CTRL_OFS;
  assign rd_stat = {araddr[`HBG_ADDR_W-1:2], 2'b00} == `HBG_STAT_OFS;
  assign rd_mux  = rd_ctrl ? {{(32 - `HBG_CTRL_W){1'b0}}, ctrl_r} :
                   rd_stat ? {{(32 - `HBG_STAT_W){1'b0}}, stat} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= HBG_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_mux;
        rresp   <= (rd_ctrl || rd_stat) ? HBG_RESP_OKAY : HBG_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pins_low_only_a;
    allow && !a_lo_n_s && !a_up_s && ctrl_r[`HBG_CTRL_UA_BIT] == 1'b0;
  endsequence

  property p_pin_low_a;
    s_pins_low_only_a |=> phase_a_lower_gate && !phase_a_upper_gate;
  endproperty
  a_pin_low_a: assert property (p_pin_low_a) else $error("phase a low gate not driven"); // RQ1

  property p_pin_high_b;
    allow && !b_up_n_s && !b_lo_s && !ctrl_r[`HBG_CTRL_LB_BIT]
      |=> phase_b_upper_gate && !phase_b_lower_gate;
  endproperty
  a_pin_high_b: assert property (p_pin_high_b) else $error("phase b high gate not driven"); // RQ1

  property p_reg_mix_off;
    ctrl_r[`HBG_CTRL_UA_BIT] && !a_lo_n_s |=> !phase_a_upper_gate && !phase_a_lower_gate;
  endproperty
  a_reg_mix_off: assert property (p_reg_mix_off) else $error("mixed request not off"); // RQ5

  property p_enable_off;
    !en_s |=> !phase_a_upper_gate && !phase_a_lower_gate
              && !phase_b_upper_gate && !phase_b_lower_gate;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("gates on while disabled"); // RQ10

  property p_reset_pin_off;
    !clr_n_s |=> !phase_a_upper_gate && !phase_b_upper_gate;
  endproperty
  a_reset_pin_off: assert property (p_reset_pin_off) else $error("gates on in reset"); // RQ6

  property p_olsel;
    $changed(ctrl_r[`HBG_CTRL_OLI_BIT])
      |=> openload_current_sel == $past(ctrl_r[`HBG_CTRL_OLI_BIT]);
  endproperty
  a_olsel: assert property (p_olsel) else $error("current select not following"); // RQ9

  property p_pulse_mode;
    pulse_run && $past(pulse_run) |=> fault_report_pin == $past(pulse_out);
  endproperty
  a_pulse_mode: assert property (p_pulse_mode) else $error("pulse not on output"); // RQ7

  property p_sleep;
    sleep_set |=> sleep_active;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered"); // RQ11

  property p_clear;
    fault_clear && !flt_s |=> !fault_latched_r;
  endproperty
  a_clear: assert property (p_clear) else $error("fault not cleared"); // RQ11
endmodule
`default_nettype wire

// ===== verification/hbg_host_model.sv
// host-side model: drives the four bridge request pins with their polarities
// assumes req changes just after a rising edge of aclk
`timescale 1ns/10ps
`default_nettype none
module hbg_host_model (
  input  wire logic       aclk,
  input  wire logic [3:0] req,
  output var  logic       phase_a_upper_req,
  output var  logic       phase_a_lower_req_n,
  output var  logic       phase_b_upper_req_n,
  output var  logic       phase_b_lower_req
);
  // req: a upper, a lower, b upper, b lower; active high
  // idle levels from time zero, then one process drives every pin
  // both requests of one phase come from the t_map patterns, with gate_enable high
  initial begin
    phase_a_upper_req   = 1'b0;
    phase_a_lower_req_n = 1'b1;
    phase_b_upper_req_n = 1'b1;
    phase_b_lower_req   = 1'b0;
    forever begin
      @(posedge aclk);
      phase_a_upper_req   <= req[0];
      phase_a_lower_req_n <= ~req[1];
      phase_b_upper_req_n <= ~req[2];
      phase_b_lower_req   <= req[3];
    end
  end
endmodule
`default_nettype wire

// ===== verification/hbg_top_bench.sv
// self-checking bench of hbg_top: pin and register control, lockout,
// fault output modes; assumes hbg_host_model drives the request pins
`timescale 1ns/10ps
`default_nettype none
`include "hbg_map.svh"
module hbg_top_bench;
  import hbg_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, gate_enable, fault_present;
  logic        fault_clear_sleep_n, fault_report_pin, openload_current_sel, sleep_active;
  logic        pa_up, pa_lo_n, pb_up_n, pb_lo;
  logic [3:0]  gates, req, wstrb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  hbg_resp_t   bresp, rresp, resp;
  int          err_count, cmp_count;

  hbg_host_model i_hbg_host_model (.aclk(aclk), .req(req), .phase_a_upper_req(pa_up),
    .phase_a_lower_req_n(pa_lo_n), .phase_b_upper_req_n(pb_up_n), .phase_b_lower_req(pb_lo));

  hbg_top #(.PULSE_CYC(100), .SLEEP_CYC(20)) i_hbg_top (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .phase_a_upper_req(pa_up),
    .phase_a_lower_req_n(pa_lo_n), .phase_b_upper_req_n(pb_up_n),
    .phase_b_lower_req(pb_lo), .gate_enable(gate_enable),
    .fault_clear_sleep_n(fault_clear_sleep_n), .fault_present(fault_present),
    .phase_a_upper_gate(gates[0]), .phase_a_lower_gate(gates[1]),
    .phase_b_upper_gate(gates[2]), .phase_b_lower_gate(gates[3]),
    .fault_report_pin(fault_report_pin), .openload_current_sel(openload_current_sel),
    .sleep_active(sleep_active));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out;
    check(32'h0, 32'h1);
    finish_test;
  endtask

  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output hbg_resp_t r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    timed_out;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output hbg_resp_t r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid === 1'b1 && arready === 1'b1) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    timed_out;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input hbg_resp_t er);
    logic [31:0] d;
    axi_rd(a, d, resp);
    check(d, exp);
    check({30'h0, resp}, {30'h0, er});
  endtask

  task automatic wr_ctrl(input logic [31:0] d);
    axi_wr(`HBG_CTRL_OFS, d, resp);
    settle;
  endtask

  function automatic logic [3:0] exp_gates(input logic [3:0] p, input logic [3:0] r);
    logic [3:0] q;
    q = p | r;
    return {q[3] & ~q[2], q[2] & ~q[3], q[1] & ~q[0], q[0] & ~q[1]};
  endfunction

  // waits for a rise, then counts high cycles up to the next rise
  task automatic pulse_chk(input int exp_hi);
    logic prev;
    int   hi;
    prev = 1'b1;
    for (int n = 0; n <= 300; n++) begin
      if (n == 300) timed_out;
      @(posedge aclk);
      if (prev === 1'b0 && fault_report_pin === 1'b1) break;
      prev = fault_report_pin;
    end
    hi = 0;
    for (int n = 1; n <= 100; n++) begin
      @(posedge aclk);
      if (n == 99) check({31'h0, fault_report_pin}, 32'h0);
      if (fault_report_pin === 1'b1) hi++;
    end
    check({31'h0, fault_report_pin}, 32'h1);
    check(hi, exp_hi);
  endtask

  task automatic t_reset;
    check({28'h0, gates}, 32'h0);
    check({29'h0, fault_report_pin, openload_current_sel, sleep_active}, 32'h0);
    rd_chk(`HBG_CTRL_OFS, 32'h0, HBG_RESP_OKAY);
    rd_chk(`HBG_STAT_OFS, 32'h40, HBG_RESP_OKAY);
    axi_wr(`HBG_STAT_OFS, 32'h7F, resp);
    check({30'h0, resp}, {30'h0, HBG_RESP_OKAY});
    rd_chk(`HBG_STAT_OFS, 32'h40, HBG_RESP_OKAY);
    axi_wr(8'h08, 32'h7F, resp);
    check({30'h0, resp}, {30'h0, HBG_RESP_SLVERR});
    rd_chk(8'h08, 32'h0, HBG_RESP_SLVERR);
    rd_chk(`HBG_CTRL_OFS, 32'h0, HBG_RESP_OKAY);
    $display("test reset done");
  endtask

  // every pin pattern against every register pattern
  task automatic t_map;
    for (int p = 0; p < 16; p++) begin
      for (int r = 0; r < 16; r++) begin
        req <= p[3:0];
        wr_ctrl({28'h0, r[3:0]});
        check({28'h0, gates}, {28'h0, exp_gates(p[3:0], r[3:0])});
      end
    end
    $display("test mapping done");
  endtask

  task automatic t_enable;
    req <= 4'h1;
    wr_ctrl(32'h8);
    check({28'h0, gates}, 32'h9);
    gate_enable <= 1'b0;
    settle;
    check({28'h0, gates}, 32'h0);
    gate_enable <= 1'b1;
    settle;
    check({28'h0, gates}, 32'h9);
    $display("test enable done");
  endtask

  task automatic t_fault;
    req <= 4'h0;
    wr_ctrl(32'h10);
    pulse_chk(20);
    fault_present <= 1'b1;
    settle;
    pulse_chk(80);
    fault_present <= 1'b0;
    pulse_chk(80);
    fault_clear_sleep_n <= 1'b0;
    repeat (3) @(posedge aclk);
    fault_clear_sleep_n <= 1'b1;
    settle;
    pulse_chk(20);
    wr_ctrl(32'h0);
    check({31'h0, fault_report_pin}, 32'h0);
    fault_present <= 1'b1;
    settle;
    check({31'h0, fault_report_pin}, 32'h1);
    fault_present <= 1'b0;
    wr_ctrl(32'h20);
    check({31'h0, fault_report_pin}, 32'h0);
    rd_chk(`HBG_STAT_OFS, 32'h50, HBG_RESP_OKAY);
    wr_ctrl(32'h30);
    check({31'h0, fault_report_pin}, 32'h0);
    $display("test fault output done");
  endtask

  task automatic t_sleep;
    req <= 4'h1;
    wr_ctrl(32'h0);
    check({28'h0, gates}, 32'h1);
    fault_clear_sleep_n <= 1'b0;
    settle;
    check({27'h0, sleep_active, gates}, 32'h0);
    repeat (25) @(posedge aclk);
    check({31'h0, sleep_active}, 32'h1);
    fault_clear_sleep_n <= 1'b1;
    settle;
    check({27'h0, sleep_active, gates}, 32'h1);
    $display("test sleep done");
  endtask

  task automatic t_oli;
    wr_ctrl(32'h40);
    check({31'h0, openload_current_sel}, 32'h1);
    rd_chk(`HBG_CTRL_OFS, 32'h40, HBG_RESP_OKAY);
    wr_ctrl(32'h0);
    check({31'h0, openload_current_sel}, 32'h0);
    $display("test open-load select done");
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    req = 4'h0;
    gate_enable = 1'b1;
    fault_clear_sleep_n = 1'b1;
    fault_present = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset;
    t_map;
    t_enable;
    t_fault;
    t_sleep;
    t_oli;
    finish_test;
  end
endmodule
`default_nettype wire
